// File: verilog/fsq_host.sv
// Host-side sequencer that drives a parallel flash through its pins.
// Assumes a synchronous software port and flash data inputs already in
// the clock domain; one bus cycle at a time, no overlap.
`timescale 1ns/1ps

module fsq_host (
    input  wire logic                       i_clock,
    input  wire logic                       i_rst_n,
    input  wire logic [7:0]                 i_sw_addr,
    input  wire logic [31:0]                i_sw_wdata,
    input  wire logic                       i_sw_write,
    input  wire logic                       i_sw_read,
    output logic      [31:0]                o_sw_rdata,
    input  wire logic [fsq_pkg::DATA_W-1:0] i_flash_dq,
    output fsq_pkg::fsq_pins_t              o_flash
);

    // ------------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE, ST_PRE_WR, ST_PRE_RD, ST_CMD1, ST_CMD2,
        ST_POLL_RD, ST_CLR_WR, ST_FINAL_WR, ST_ARRAY_RD
    } fsq_state_t;

    localparam logic [fsq_pkg::CNT_W-1:0] WR_LAST =
        fsq_pkg::CNT_W'(fsq_pkg::WE_LOW_CYC + fsq_pkg::WE_HIGH_CYC - 1);
    localparam logic [fsq_pkg::CNT_W-1:0] CNT_ONE = 4'h1;

    fsq_state_t                   state_q, state_d;
    logic [fsq_pkg::CNT_W-1:0]    cnt_q, cnt_d;
    fsq_pkg::fsq_op_t             op_q, op_d;
    logic [fsq_pkg::ADDR_W-1:0]   addr_q, addr_d;
    logic [1:0]                   cfg_q, cfg_d;
    logic [7:0]                   sr_q, sr_d;
    logic [fsq_pkg::DATA_W-1:0]   arr_q, arr_d;
    logic                         susp_q, susp_d;
    logic                         err_q, err_d;
    logic                         done_q, done_d;
    fsq_pkg::fsq_pins_t           pins_q, pins_d;
    logic [31:0]                  rdata_q, rdata_d;
    logic [7:0]                   cmd;

    wire wr_last  = (cnt_q == WR_LAST);
    wire rd_last  = (cnt_q == fsq_pkg::READ_CYC);
    wire is_wr    = (state_q == ST_PRE_WR) || (state_q == ST_CMD1) || (state_q == ST_CMD2)
                 || (state_q == ST_CLR_WR) || (state_q == ST_FINAL_WR);
    wire last     = is_wr ? wr_last : rd_last;
    wire is_lock  = (op_q == fsq_pkg::OP_SET_BLOCK_LOCK) || (op_q == fsq_pkg::OP_SET_PERM_LOCK)
                 || (op_q == fsq_pkg::OP_CLEAR_LOCKS);
    wire ready    = i_flash_dq[fsq_pkg::SR_READY];
    wire err_now  = |(i_flash_dq[7:0] & fsq_pkg::SR_ERR_MASK);
    // Deferred checking lets a series of lock sets share one check
    wire need_chk = (op_q == fsq_pkg::OP_CLEAR_LOCKS)
                 || (is_lock && cfg_q[fsq_pkg::CFG_CHECK_EACH]);
    wire sw_wr    = i_sw_write && (state_q == ST_IDLE);
    wire start    = sw_wr && (i_sw_addr == fsq_pkg::REG_CTRL);
    wire [2:0] new_op = i_sw_wdata[fsq_pkg::CTRL_OP_W-1:0];
    wire new_lock = (new_op == fsq_pkg::OP_SET_BLOCK_LOCK) || (new_op == fsq_pkg::OP_SET_PERM_LOCK)
                 || (new_op == fsq_pkg::OP_CLEAR_LOCKS);

    // ------------------------------------------------------------------
    // Control next state
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        cnt_d   = last ? '0 : cnt_q + CNT_ONE;
        op_d    = op_q;
        addr_d  = addr_q;
        cfg_d   = cfg_q;
        sr_d    = sr_q;
        arr_d   = arr_q;
        susp_d  = susp_q;
        err_d   = err_q;
        done_d  = done_q;
        if (i_sw_write && i_sw_addr == fsq_pkg::REG_CONFIG) begin
            cfg_d = i_sw_wdata[1:0];
        end
        if (sw_wr && i_sw_addr == fsq_pkg::REG_ADDR) begin
            addr_d = i_sw_wdata[fsq_pkg::ADDR_W-1:0];
        end
        case (state_q)
            ST_IDLE: begin
                cnt_d = '0;
                if (start) begin
                    op_d    = fsq_pkg::fsq_op_t'(new_op);
                    done_d  = 1'b0;
                    err_d   = 1'b0;
                    state_d = new_lock ? ST_PRE_WR : ST_CMD1;
                end
            end
            ST_PRE_WR: if (wr_last) state_d = ST_PRE_RD;
            ST_PRE_RD: begin
                if (rd_last) begin
                    sr_d = i_flash_dq[7:0];
                    if (ready) begin
                        state_d = ST_CMD1;
                    end
                end
            end
            ST_CMD1: begin
                if (wr_last) begin
                    case (op_q)
                        fsq_pkg::OP_SUSPEND:     state_d = ST_POLL_RD;
                        fsq_pkg::OP_READ_ARRAY:  state_d = ST_ARRAY_RD;
                        fsq_pkg::OP_READ_STATUS: state_d = ST_POLL_RD;
                        fsq_pkg::OP_RESUME: begin
                            susp_d  = 1'b0;
                            state_d = ST_IDLE;
                        end
                        fsq_pkg::OP_CLEAR_STATUS: state_d = ST_IDLE;
                        default:                  state_d = ST_CMD2;
                    endcase
                end
            end
            ST_CMD2: if (wr_last) state_d = ST_POLL_RD;
            ST_POLL_RD: begin
                if (rd_last) begin
                    sr_d = i_flash_dq[7:0];
                    if (ready || op_q == fsq_pkg::OP_READ_STATUS) begin
                        if (op_q == fsq_pkg::OP_SUSPEND) begin
                            // Erase and write suspend share one handshake
                            susp_d = i_flash_dq[fsq_pkg::SR_WRITE_SUSP]
                                   | i_flash_dq[fsq_pkg::SR_ERASE_SUSP];
                        end
                        if (need_chk && err_now) begin
                            // Device keeps error bits until told otherwise
                            err_d = 1'b1;
                            if (cfg_q[fsq_pkg::CFG_AUTO_CLEAR]) begin
                                state_d = ST_CLR_WR;
                            end else if (op_q == fsq_pkg::OP_CLEAR_LOCKS) begin
                                state_d = ST_FINAL_WR;
                            end else begin
                                state_d = ST_IDLE;
                            end
                        end else if (op_q == fsq_pkg::OP_CLEAR_LOCKS) begin
                            state_d = ST_FINAL_WR;
                        end else begin
                            state_d = ST_IDLE;
                        end
                    end
                end
            end
            ST_CLR_WR: begin
                if (wr_last) begin
                    state_d = (op_q == fsq_pkg::OP_CLEAR_LOCKS) ? ST_FINAL_WR : ST_IDLE;
                end
            end
            ST_FINAL_WR: if (wr_last) state_d = ST_IDLE;
            ST_ARRAY_RD: begin
                if (rd_last) begin
                    arr_d   = i_flash_dq;
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
        if (state_q != ST_IDLE && state_d == ST_IDLE) begin
            done_d = 1'b1;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= ST_IDLE;
            cnt_q   <= '0;
            op_q    <= fsq_pkg::OP_READ_STATUS;
            addr_q  <= '0;
            cfg_q   <= fsq_pkg::CFG_RESET;
            sr_q    <= '0;
            arr_q   <= '0;
            susp_q  <= 1'b0;
            err_q   <= 1'b0;
            done_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            op_q    <= op_d;
            addr_q  <= addr_d;
            cfg_q   <= cfg_d;
            sr_q    <= sr_d;
            arr_q   <= arr_d;
            susp_q  <= susp_d;
            err_q   <= err_d;
            done_q  <= done_d;
        end
    end

    // ------------------------------------------------------------------
    // Flash pins
    // ------------------------------------------------------------------
    // Pins lag the state by one cycle, so data holds while strobes rise
    always_comb begin
        cmd = fsq_pkg::CMD_PAD;
        case (state_q)
            ST_PRE_WR:   cmd = fsq_pkg::CMD_READ_STATUS;
            ST_CLR_WR:   cmd = fsq_pkg::CMD_CLEAR_STATUS;
            ST_FINAL_WR: cmd = fsq_pkg::CMD_READ_ARRAY;
            ST_CMD1: begin
                case (op_q)
                    fsq_pkg::OP_SUSPEND:      cmd = fsq_pkg::CMD_SUSPEND;
                    fsq_pkg::OP_RESUME:       cmd = fsq_pkg::CMD_RESUME;
                    fsq_pkg::OP_READ_ARRAY:   cmd = fsq_pkg::CMD_READ_ARRAY;
                    fsq_pkg::OP_CLEAR_STATUS: cmd = fsq_pkg::CMD_CLEAR_STATUS;
                    fsq_pkg::OP_READ_STATUS:  cmd = fsq_pkg::CMD_READ_STATUS;
                    default:                  cmd = fsq_pkg::CMD_LOCK_SETUP;
                endcase
            end
            ST_CMD2: begin
                case (op_q)
                    fsq_pkg::OP_SET_BLOCK_LOCK: cmd = fsq_pkg::CMD_BLOCK_LOCK;
                    fsq_pkg::OP_SET_PERM_LOCK:  cmd = fsq_pkg::CMD_PERM_LOCK;
                    default:                    cmd = fsq_pkg::CMD_CLEAR_LOCKS;
                endcase
            end
            default: cmd = fsq_pkg::CMD_PAD;
        endcase
        pins_d         = fsq_pkg::PINS_RESET;
        pins_d.rst_n   = 1'b1;
        pins_d.addr    = addr_q;
        if (is_wr) begin
            pins_d.dq_oe_n = 1'b0;
            pins_d.dq      = {{(fsq_pkg::DATA_W-8){1'b0}}, cmd};
            if (cnt_q < fsq_pkg::WE_LOW_CYC) begin
                pins_d.ce_n = 1'b0;
                pins_d.we_n = 1'b0;
            end
        end else if (state_q != ST_IDLE && cnt_q < fsq_pkg::READ_CYC) begin
            pins_d.ce_n = 1'b0;
            pins_d.oe_n = 1'b0;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pins_q <= fsq_pkg::PINS_RESET;
        end else begin
            pins_q <= pins_d;
        end
    end

    assign o_flash = pins_q;

    // ------------------------------------------------------------------
    // Software read port
    // ------------------------------------------------------------------
    always_comb begin
        rdata_d = '0;
        if (i_sw_read) begin
            case (i_sw_addr)
                fsq_pkg::REG_CTRL:   rdata_d = 32'({op_q});
                fsq_pkg::REG_CONFIG: rdata_d = 32'(cfg_q);
                fsq_pkg::REG_ADDR:   rdata_d = 32'(addr_q);
                fsq_pkg::REG_STATUS: rdata_d = 32'({err_q, susp_q, done_q,
                                                    state_q != ST_IDLE, sr_q});
                fsq_pkg::REG_RDATA:  rdata_d = 32'(arr_q);
                default:             rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign o_sw_rdata = rdata_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    suspend_code_a: assert property (
        (state_q == ST_CMD1 && op_q == fsq_pkg::OP_SUSPEND && cnt_q == 0)
        |=> (!pins_q.we_n && !pins_q.dq_oe_n && pins_q.dq[7:0] == fsq_pkg::CMD_SUSPEND))
        else $error("suspend code wrong");
    resume_code_a: assert property (
        (state_q == ST_CMD1 && op_q == fsq_pkg::OP_RESUME && wr_last)
        |=> (state_q == ST_IDLE && !susp_q && pins_q.dq[7:0] == fsq_pkg::CMD_RESUME))
        else $error("resume handling wrong");
    suspend_flag_a: assert property (
        (state_q == ST_POLL_RD && op_q == fsq_pkg::OP_SUSPEND && rd_last && ready)
        |=> susp_q == ($past(i_flash_dq[fsq_pkg::SR_WRITE_SUSP])
                     | $past(i_flash_dq[fsq_pkg::SR_ERASE_SUSP])))
        else $error("suspend flag not captured");
    array_entry_a: assert property (
        $rose(state_q == ST_ARRAY_RD)
        |-> ($past(state_q) == ST_CMD1 && pins_q.dq[7:0] == fsq_pkg::CMD_READ_ARRAY))
        else $error("array read without read array command");
    lock_setup_a: assert property (
        (state_q == ST_CMD1 && is_lock && cnt_q == 0)
        |=> (!pins_q.we_n && pins_q.dq[7:0] == fsq_pkg::CMD_LOCK_SETUP))
        else $error("lock setup code wrong");
    lock_confirm_a: assert property (
        (state_q == ST_CMD2 && cnt_q == 0)
        |=> (!pins_q.we_n && pins_q.addr == addr_q && pins_q.dq[7:0] ==
             ((op_q == fsq_pkg::OP_SET_BLOCK_LOCK) ? fsq_pkg::CMD_BLOCK_LOCK :
              (op_q == fsq_pkg::OP_SET_PERM_LOCK) ? fsq_pkg::CMD_PERM_LOCK :
              fsq_pkg::CMD_CLEAR_LOCKS)))
        else $error("lock confirm code wrong");
    final_array_a: assert property (
        (state_q == ST_POLL_RD && op_q == fsq_pkg::OP_CLEAR_LOCKS && rd_last && ready)
        |=> ##[1:4] (state_q == ST_FINAL_WR))
        else $error("clear lock-bits not followed by read array");
    deferred_check_a: assert property (
        (state_q == ST_POLL_RD && op_q == fsq_pkg::OP_SET_BLOCK_LOCK && rd_last && ready
         && !cfg_q[fsq_pkg::CFG_CHECK_EACH])
        |=> (state_q == ST_IDLE && !err_q))
        else $error("deferred check still checked");
    error_clear_a: assert property (
        (state_q == ST_POLL_RD && rd_last && ready && need_chk && err_now
         && cfg_q[fsq_pkg::CFG_AUTO_CLEAR])
        |=> (state_q == ST_CLR_WR && err_q) ##1 (pins_q.dq[7:0] == fsq_pkg::CMD_CLEAR_STATUS))
        else $error("error not followed by clear status");
    ready_first_a: assert property (
        ($rose(state_q == ST_CMD1) && is_lock)
        |-> ($past(state_q) == ST_PRE_RD && sr_q[fsq_pkg::SR_READY]))
        else $error("lock command issued before ready");

endmodule

// File: verilog/fsq_pkg.sv
// Constants, types and command codes for the flash command sequencer.
// Assumes a 10 MHz system clock and a 16-bit parallel flash on the far side.
package fsq_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 19;
    localparam int DATA_W = 16;
    localparam int CNT_W  = 4;

    // ------------------------------------------------------------------
    // Flash command codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
    localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_SUSPEND      = 8'hB0;
    localparam logic [7:0] CMD_RESUME       = 8'hD0;
    localparam logic [7:0] CMD_LOCK_SETUP   = 8'h60;
    localparam logic [7:0] CMD_BLOCK_LOCK   = 8'h01;
    localparam logic [7:0] CMD_PERM_LOCK    = 8'hF1;
    localparam logic [7:0] CMD_CLEAR_LOCKS  = 8'hD0;
    localparam logic [7:0] CMD_PAD          = 8'h00;

    // ------------------------------------------------------------------
    // write_state_status bit positions
    // ------------------------------------------------------------------
    localparam int SR_READY      = 7;
    localparam int SR_ERASE_SUSP = 6;
    localparam int SR_WRITE_SUSP = 2;
    localparam logic [7:0] SR_ERR_MASK = 8'h3A;

    // ------------------------------------------------------------------
    // Bus cycle timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 100;
    localparam int WE_LOW_NS      = 100;
    localparam int WE_HIGH_NS     = 100;
    localparam int READ_ACCESS_NS = 200;
    localparam logic [CNT_W-1:0] WE_LOW_CYC =
        CNT_W'((WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] WE_HIGH_CYC =
        CNT_W'((WE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] READ_CYC =
        CNT_W'((READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_CONFIG = 8'h04;
    localparam logic [7:0] REG_ADDR   = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_RDATA  = 8'h10;
    localparam int CTRL_OP_W      = 3;
    localparam int CFG_AUTO_CLEAR = 0;
    localparam int CFG_CHECK_EACH = 1;
    localparam logic [1:0] CFG_RESET = 2'h3;

    typedef enum logic [CTRL_OP_W-1:0] {
        OP_SUSPEND, OP_RESUME, OP_READ_ARRAY, OP_SET_BLOCK_LOCK,
        OP_SET_PERM_LOCK, OP_CLEAR_LOCKS, OP_CLEAR_STATUS, OP_READ_STATUS
    } fsq_op_t;

    typedef struct packed {
        logic              ce_n;
        logic              oe_n;
        logic              we_n;
        logic              rst_n;
        logic              dq_oe_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq;
    } fsq_pins_t;

    localparam fsq_pins_t PINS_RESET = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
        rst_n: 1'b0, dq_oe_n: 1'b1, addr: '0, dq: '0};

endpackage

// File: bench/fsq_flash_model.sv
// Behavioural parallel flash: command decode, status byte, lock-bits.
// Assumes the bench resolves the shared data bus from the host's output enable alone.
`timescale 1ns/1ps

module fsq_flash_model (
    input  wire logic        i_ce_n,
    input  wire logic        i_oe_n,
    input  wire logic        i_we_n,
    input  wire logic        i_rst_n,
    input  wire logic [18:0] i_addr,
    input  wire logic [15:0] i_dq,
    input  wire logic        i_bg_go,
    input  wire logic        i_bg_erase,
    input  wire logic        i_low_supply,
    input  wire logic        i_fail_lock,
    input  wire integer      i_busy_ns,
    output logic      [15:0] o_dq,
    output logic             o_misuse
);
    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    logic [7:0]  sr_q;
    logic        stat_q;
    logic        setup_q;
    logic        bg_q;
    logic        perm_q = 1'b0;
    logic [15:0] last_q = 16'h0000;
    wire         drive = !i_ce_n && !i_oe_n;
    wire  [15:0] val = stat_q ? {8'h00, sr_q} : (i_addr[15:0] ^ 16'hA5C3);
    always @* if (drive) last_q = val;
    // No pull on the bus: released lines show the inverse of the last value
    assign o_dq = drive ? val : ~last_q;

    // ------------------------------------------------------------------
    // Background write or erase
    // ------------------------------------------------------------------
    always @(posedge i_bg_go) begin
        bg_q = 1'b1;
        sr_q[7] = 1'b0;
        sr_q[7] <= #(i_busy_ns * 4) 1'b1;
    end

    // ------------------------------------------------------------------
    // Command decode on the write strobe rise
    // ------------------------------------------------------------------
    // Host lifts both enables together, so latch on whichever rises first
    wire         wr_strobe_n = i_ce_n | i_we_n;
    always @(posedge wr_strobe_n or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sr_q = 8'h80;
            stat_q = 1'b0;
            setup_q = 1'b0;
            bg_q = 1'b0;
            o_misuse = 1'b0;
        end else if (setup_q) begin
            setup_q = 1'b0;
            stat_q = 1'b1;
            if (!sr_q[7]) o_misuse = 1'b1;
            sr_q[7] = 1'b0;
            sr_q[7] <= #(i_busy_ns) 1'b1;
            if (i_low_supply) sr_q[3] = 1'b1;
            else case (i_dq[7:0])
                8'h01: if (perm_q) sr_q[1] = 1'b1; else if (i_fail_lock) sr_q[4] = 1'b1;
                8'hF1: perm_q = 1'b1;
                8'hD0: if (i_fail_lock) sr_q[5] = 1'b1;
                default: sr_q[5:4] = 2'h3;
            endcase
        end else begin
            case (i_dq[7:0])
                8'h70: stat_q = 1'b1;
                8'h50: sr_q = sr_q & ~8'h3A;
                8'hFF: stat_q = 1'b0;
                8'h60: setup_q = 1'b1;
                8'hB0: begin
                    stat_q = 1'b1;
                    if (bg_q && !sr_q[7]) begin
                        sr_q[i_bg_erase ? 6 : 2] = 1'b1;
                        sr_q[7] <= #50 1'b1;
                    end
                end
                8'hD0: if (sr_q[2] || sr_q[6]) begin
                    sr_q[6] = 1'b0;
                    sr_q[2] = 1'b0;
                    sr_q[7] = 1'b0;
                    sr_q[7] <= #(i_busy_ns) 1'b1;
                end
                default: sr_q[5:4] = 2'h3;
            endcase
        end
    end
endmodule

// File: bench/fsq_host_bench.sv
// Self-checking bench for the flash command sequencer.
// Assumes the design package and the behavioural flash model.
`timescale 1ns/1ps

module fsq_host_bench;
    logic               clk;
    logic               rst_n = 1'b0;
    logic               sw_write = 1'b0;
    logic               sw_read = 1'b0;
    logic [7:0]         sw_addr = 8'h00;
    logic [31:0]        sw_wdata = 32'h0;
    logic [31:0]        sw_rdata;
    logic [31:0]        rd;
    fsq_pkg::fsq_pins_t pins;
    logic [15:0]        model_dq;
    logic [15:0]        flash_dq;
    logic               bg_go = 1'b0;
    logic               bg_erase = 1'b0;
    logic               low_supply = 1'b0;
    logic               fail_lock = 1'b0;
    logic               misuse;
    logic [18:0]        seen_addr;
    logic [18:0]        addr;
    logic [7:0]         seen_q[$];
    logic [7:0]         exp_q[$];
    int                 busy_ns = 300;
    int                 err_count = 0;
    int                 tests_run = 0;
    int                 cycles = 0;
    int                 seed = 38090;

    // ------------------------------------------------------------------
    // Clock, bus resolution, instances
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    assign flash_dq = !pins.dq_oe_n ? pins.dq : model_dq;

    fsq_host dut (.i_clock(clk), .i_rst_n(rst_n), .i_sw_addr(sw_addr), .i_sw_wdata(sw_wdata),
        .i_sw_write(sw_write), .i_sw_read(sw_read), .o_sw_rdata(sw_rdata),
        .i_flash_dq(flash_dq), .o_flash(pins));
    fsq_flash_model flash (.i_ce_n(pins.ce_n), .i_oe_n(pins.oe_n), .i_we_n(pins.we_n),
        .i_rst_n(pins.rst_n), .i_addr(pins.addr), .i_dq(flash_dq), .i_bg_go(bg_go),
        .i_bg_erase(bg_erase), .i_low_supply(low_supply), .i_fail_lock(fail_lock),
        .i_busy_ns(busy_ns), .o_dq(model_dq), .o_misuse(misuse));

    // Every command byte the device accepts, in order
    always @(posedge (pins.we_n | pins.ce_n)) begin
        seen_q.push_back(flash_dq[7:0]);
        if (flash_dq[7:0] == 8'h01) seen_addr = pins.addr;
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic sw_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_write <= 1'b1;
        @(posedge clk);
        sw_write <= 1'b0;
    endtask
    task automatic sw_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        sw_addr <= a;
        sw_read <= 1'b1;
        @(posedge clk);
        sw_read <= 1'b0;
        #1 d = sw_rdata;
    endtask
    // Start an op, wait for idle, compare command stream and status
    task automatic run(input logic [2:0] op, input logic [7:0] sr, input bit chk_sr,
                       input bit chk_err, input logic err);
        int n;
        seen_q.delete();
        sw_wr(fsq_pkg::REG_CTRL, {29'h0, op});
        n = 0;
        do begin
            sw_rd(fsq_pkg::REG_STATUS, rd);
            n++;
        end while (rd[8] !== 1'b0 && n < 3000);
        check(32'(rd[9]), 32'h1);
        check(32'(seen_q.size()), 32'(exp_q.size()));
        foreach (exp_q[i]) check(32'(seen_q[i]), 32'(exp_q[i]));
        if (chk_sr) check(32'(rd[7:0]), 32'(sr));
        if (chk_err) check(32'(rd[11]), 32'(err));
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            err_count++;
            close_out();
        end
    end

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        check(32'({pins.rst_n, pins.ce_n, pins.we_n, pins.dq_oe_n}), 32'h7);
        rst_n <= 1'b1;
        @(posedge clk);
        #1 check(32'(pins.rst_n), 32'h1);
        sw_rd(fsq_pkg::REG_CONFIG, rd);
        check(32'(rd[1:0]), 32'h3);
        sw_rd(8'h3C, rd);
        check(rd, 32'h0);
        exp_q = '{8'h70, 8'h60, 8'h01};
        for (int i = 0; i < 4; i++) begin
            addr = 19'($random(seed));
            busy_ns = (i % 2) ? 6000 : 150;
            sw_wr(fsq_pkg::REG_ADDR, {13'h0, addr});
            run(3'h3, 8'h80, 1, 1, 1'b0);
            check(32'(seen_addr), 32'(addr));
        end
        bg_go <= 1'b1;
        run(3'h3, 8'h80, 1, 1, 1'b0);
        bg_go <= 1'b0;
        // Slow background work so the suspend lands mid-operation
        for (int k = 0; k < 2; k++) begin
            busy_ns = 20000;
            bg_erase <= k[0];
            @(posedge clk);
            bg_go <= 1'b1;
            exp_q = '{8'hB0};
            run(3'h0, k ? 8'hC0 : 8'h84, 1, 0, 1'b0);
            check(32'(rd[10]), 32'h1);
            exp_q = '{8'hFF};
            run(3'h2, 8'h00, 0, 0, 1'b0);
            sw_rd(fsq_pkg::REG_RDATA, rd);
            check(rd, {16'h0, addr[15:0] ^ 16'hA5C3});
            exp_q = '{8'hD0};
            run(3'h1, 8'h00, 0, 0, 1'b0);
            check(32'(rd[10]), 32'h0);
            bg_go <= 1'b0;
        end
        busy_ns = 150;
        bg_erase <= 1'b0;
        exp_q = '{8'h70, 8'h60, 8'hD0, 8'hFF};
        run(3'h5, 8'h80, 1, 1, 1'b0);
        exp_q = '{8'hB0};
        run(3'h0, 8'h80, 1, 0, 1'b0);
        check(32'(rd[10]), 32'h0);
        fail_lock <= 1'b1;
        exp_q = '{8'h70, 8'h60, 8'h01, 8'h50};
        run(3'h3, 8'h90, 1, 1, 1'b1);
        low_supply <= 1'b1;
        exp_q = '{8'h70, 8'h60, 8'hD0, 8'h50, 8'hFF};
        run(3'h5, 8'h88, 1, 1, 1'b1);
        low_supply <= 1'b0;
        // Deferred checking: errors must survive the next lock operation
        sw_wr(fsq_pkg::REG_CONFIG, 32'h0);
        exp_q = '{8'h70, 8'h60, 8'h01};
        run(3'h3, 8'h90, 1, 1, 1'b0);
        fail_lock <= 1'b0;
        run(3'h3, 8'h90, 1, 0, 1'b0);
        exp_q = '{8'h70};
        run(3'h7, 8'h90, 1, 0, 1'b0);
        exp_q = '{8'h50};
        run(3'h6, 8'h00, 0, 0, 1'b0);
        exp_q = '{8'h70};
        run(3'h7, 8'h80, 1, 0, 1'b0);
        sw_wr(fsq_pkg::REG_CONFIG, 32'h3);
        exp_q = '{8'h70, 8'h60, 8'hF1};
        run(3'h4, 8'h80, 1, 1, 1'b0);
        exp_q = '{8'h70, 8'h60, 8'h01, 8'h50};
        run(3'h3, 8'h82, 1, 1, 1'b1);
        check(32'(misuse), 32'h0);
        close_out();
    end
endmodule
